// [rtl/ltmc_host.sv]
// host controller steering the transceiver through its pins
// assumes device pins reach us asynchronously; one 20 MHz clock
//
// Contract
// - power-on samples fault/slope pin and latches the slope choice
// - host does not raise wake until the ignore interval elapsed
// - after overload device is start-up ready; host toggles wake again
// - host classifies fault: rx low tx high contention, rx high tx low thermal
// - host must not drive transmit data high while device shut down
`timescale 1ns/1ps
module ltmc_host
#(
    parameter int unsigned IGNORE_CYCLES = ltmc_pkg::IGNORE_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    // user side
    input wire logic pwr_good,
    input wire logic go_oper,
    input wire logic go_down,
    input wire logic user_txd,
    output logic user_rxd,
    output logic link_up,
    output logic slope_fast,
    output logic [2:0] mode,
    output logic [1:0] fault_class,
    // device pins
    input wire logic rxd_pin,
    input wire logic fault_slope_pin_in,
    output logic fault_slope_pin_out,
    output logic fault_slope_pin_oe_n,
    output logic cs_wake_pin,
    output logic txd_pin,
    output logic txd_pin_oe_n
);
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic srst_n;
    logic rxd_s;
    logic flt_s;
    logic pwr_s;
    logic pwr_q_reg;
    ltmc_pkg::ltmc_mode_t mode_reg;
    logic [ltmc_pkg::CNT_W-1:0] cnt_reg;
    logic txd_q_reg;
    logic cnt_done;

    // ========================================================
    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign srst_n = rst_s2_reg;

    // ========================================================
    // pin synchronisers
    ltmc_sync #(.INIT(1'b1)) u_rxd
    (
        .clk(clk),
        .rst_n(srst_n),
        .pin(rxd_pin),
        .level(rxd_s)
    );
    ltmc_sync #(.INIT(1'b1)) u_flt
    (
        .clk(clk),
        .rst_n(srst_n),
        .pin(fault_slope_pin_in),
        .level(flt_s)
    );
    ltmc_sync #(.INIT(1'b0)) u_pwr
    (
        .clk(clk),
        .rst_n(srst_n),
        .pin(pwr_good),
        .level(pwr_s)
    );

    function automatic logic [ltmc_pkg::CNT_W-1:0] sat_dec(
        input logic [ltmc_pkg::CNT_W-1:0] v);
        sat_dec = (v == '0) ? v : v - 16'h0001;
    endfunction

    assign cnt_done = (cnt_reg == '0);

    // ========================================================
    // device mode tracking; the host mirrors the device states so that
    // wake edges are only produced where the device accepts them
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            mode_reg <= ltmc_pkg::LTMC_OFF;
            cnt_reg <= '0;
            cs_wake_pin <= 1'b0;
            pwr_q_reg <= 1'b0;
        end
        else
        begin
            pwr_q_reg <= pwr_s;
            cnt_reg <= sat_dec(cnt_reg);
            if (!pwr_s)
            begin
                // supply gone: device will redo power-on
                mode_reg <= ltmc_pkg::LTMC_OFF;
                cs_wake_pin <= 1'b0;
            end
            else
                case (mode_reg)
                    ltmc_pkg::LTMC_OFF:
                    begin
                        // wake held low at power-on selects ordinary ready
                        mode_reg <= ltmc_pkg::LTMC_READY;
                        cnt_reg <= IGNORE_CYCLES[ltmc_pkg::CNT_W-1:0];
                    end
                    ltmc_pkg::LTMC_STARTUP:
                    begin
                        // falling edge needed before a rising one counts;
                        // wait for the fault pin to clear, else the device
                        // is still shut down and would miss the edge
                        if (cnt_done && flt_s)
                        begin
                            cs_wake_pin <= 1'b0;
                            mode_reg <= ltmc_pkg::LTMC_READY;
                        end
                    end
                    ltmc_pkg::LTMC_READY:
                    begin
                        // no rising edge inside the ignore window
                        if (go_oper && cnt_done)
                        begin
                            cs_wake_pin <= 1'b1;
                            mode_reg <= ltmc_pkg::LTMC_OPER;
                        end
                    end
                    ltmc_pkg::LTMC_OPER:
                    begin
                        if (go_down)
                        begin
                            cs_wake_pin <= 1'b0;
                            mode_reg <= ltmc_pkg::LTMC_DOWN;
                        end
                        else if (fault_class_reg_thermal())
                        begin
                            // device recovers into start-up ready
                            mode_reg <= ltmc_pkg::LTMC_STARTUP;
                            cnt_reg <=
                                ltmc_pkg::WAKE_LOW_CYC[ltmc_pkg::CNT_W-1:0];
                        end
                    end
                    ltmc_pkg::LTMC_DOWN:
                    begin
                        if (go_oper)
                        begin
                            cs_wake_pin <= 1'b1;
                            mode_reg <= ltmc_pkg::LTMC_OPER;
                        end
                        else if (!rxd_s)
                        begin
                            // bus wake: regulator comes up, then ready
                            mode_reg <= ltmc_pkg::LTMC_READY;
                            cnt_reg <= '0;
                        end
                    end
                    default:
                        mode_reg <= ltmc_pkg::LTMC_OFF;
                endcase
        end
    end

    function automatic logic fault_class_reg_thermal();
        fault_class_reg_thermal = (fault_class == 2'(ltmc_pkg::LTMC_F_THERMAL));
    endfunction

    // ========================================================
    // transmit drive: only in operation, released otherwise so the
    // pin is never actively high while the device is unpowered
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            txd_pin <= 1'b1;
            txd_pin_oe_n <= 1'b1;
            txd_q_reg <= 1'b1;
        end
        else
        begin
            txd_q_reg <= txd_pin;
            if (mode_reg == ltmc_pkg::LTMC_OPER)
            begin
                txd_pin <= user_txd;
                txd_pin_oe_n <= 1'b0;
            end
            else
            begin
                txd_pin <= 1'b1;
                txd_pin_oe_n <= 1'b1;
            end
        end
    end

    // ========================================================
    // slope strap followed while the supply is down and frozen once it is
    // good; both syncs share one delay, so the last sample is from power-on
    // and the pin is never driven
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            slope_fast <= 1'b0;
            fault_slope_pin_out <= 1'b0;
            fault_slope_pin_oe_n <= 1'b1;
        end
        else if (!pwr_s)
            slope_fast <= (flt_s == ltmc_pkg::SLOPE_FAST);
    end

    // ========================================================
    // fault classification from transmit and receive levels; a short
    // blip after each transmit toggle is normal so it is qualified by
    // transmit having been stable for a cycle
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
            fault_class <= 2'(ltmc_pkg::LTMC_F_NONE);
        else if (mode_reg != ltmc_pkg::LTMC_OPER || txd_q_reg != txd_pin
                 || flt_s)
            fault_class <= 2'(ltmc_pkg::LTMC_F_NONE);
        else if (!rxd_s && txd_pin)
            fault_class <= 2'(ltmc_pkg::LTMC_F_CONTENTION);
        else if (rxd_s && !txd_pin)
            fault_class <= 2'(ltmc_pkg::LTMC_F_THERMAL);
        else
            fault_class <= 2'(ltmc_pkg::LTMC_F_NONE);
    end

    // ========================================================
    // user status
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            user_rxd <= 1'b1;
            link_up <= 1'b0;
            mode <= 3'h0;
        end
        else
        begin
            user_rxd <= rxd_s;
            link_up <= (mode_reg == ltmc_pkg::LTMC_OPER);
            mode <= mode_reg;
        end
    end

    // ========================================================
    // checks
    a_no_early_wake: assert property (@(posedge clk) disable iff (!srst_n)
        $rose(cs_wake_pin) && $past(mode_reg) == ltmc_pkg::LTMC_READY
        |-> $past(cnt_done))
        else $error("wake raised inside ignore window");
    a_down_from_oper: assert property (@(posedge clk) disable iff (!srst_n)
        mode_reg == ltmc_pkg::LTMC_DOWN && $past(mode_reg) !=
        ltmc_pkg::LTMC_DOWN |-> $past(mode_reg) == ltmc_pkg::LTMC_OPER)
        else $error("power-down entered not from operation");
    a_tx_released: assert property (@(posedge clk) disable iff (!srst_n)
        mode_reg != ltmc_pkg::LTMC_OPER |=> txd_pin_oe_n)
        else $error("transmit driven outside operation");
    a_tx_follows: assert property (@(posedge clk) disable iff (!srst_n)
        mode_reg == ltmc_pkg::LTMC_OPER |=> txd_pin == $past(user_txd))
        else $error("transmit does not follow user data");
    a_fall_to_down: assert property (@(posedge clk) disable iff (!srst_n)
        $past(mode_reg) == ltmc_pkg::LTMC_OPER &&
        mode_reg == ltmc_pkg::LTMC_DOWN |-> !cs_wake_pin)
        else $error("power-down without wake falling");
    a_rise_to_oper: assert property (@(posedge clk) disable iff (!srst_n)
        mode_reg == ltmc_pkg::LTMC_OPER |-> cs_wake_pin)
        else $error("operation without wake high");
    a_rx_follows: assert property (@(posedge clk) disable iff (!srst_n)
        1'b1 |=> user_rxd == $past(rxd_s))
        else $error("receive output not following bus");
    a_strap_held: assert property (@(posedge clk) disable iff (!srst_n)
        pwr_q_reg |-> $stable(slope_fast))
        else $error("slope choice changed outside power-up");
    c_oper: cover property (@(posedge clk) disable iff (!srst_n)
        mode_reg == ltmc_pkg::LTMC_OPER);
    c_down: cover property (@(posedge clk) disable iff (!srst_n)
        mode_reg == ltmc_pkg::LTMC_DOWN);
    c_bus_wake: cover property (@(posedge clk) disable iff (!srst_n)
        $past(mode_reg) == ltmc_pkg::LTMC_DOWN &&
        mode_reg == ltmc_pkg::LTMC_READY);
endmodule

// [inc/ltmc_pkg.sv]
// package of constants for the host-side transceiver mode controller
// assumes a 20 MHz system clock; the transceiver is reached only by pins
package ltmc_pkg;
    // ========================================================
    // timing
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned IGNORE_US = 600;
    // least time: microseconds times whole MHz, no rounding, never below one cycle
    localparam int unsigned IGNORE_CYC =
        (IGNORE_US * (CLK_HZ / 1000000) + 0) > 0 ?
        IGNORE_US * (CLK_HZ / 1000000) : 1;
    // settle time in start-up ready, with wake still high, before wake is taken low, in cycles
    localparam int unsigned WAKE_LOW_CYC = 20;
    localparam int unsigned CNT_W = 16;
    // ========================================================
    // slope choice encoding, as seen on the fault/slope pin at power-up
    localparam logic SLOPE_NORMAL = 1'b1;
    localparam logic SLOPE_FAST = 1'b0;
    // ========================================================
    // host view of the device mode
    typedef enum logic [2:0] {
        LTMC_OFF,
        LTMC_STARTUP,
        LTMC_READY,
        LTMC_WAKE_LOW,
        LTMC_OPER,
        LTMC_DOWN
    } ltmc_mode_t;
    // ========================================================
    // fault classes read back from the pins
    typedef enum logic [1:0] {
        LTMC_F_NONE,
        LTMC_F_CONTENTION,
        LTMC_F_THERMAL
    } ltmc_fault_t;
endpackage

// [rtl/ltmc_sync.sv]
// three-flop synchroniser for pin inputs with agreement filter
// assumes one clock; the first flop feeds only the second
`timescale 1ns/1ps
module ltmc_sync
#(
    parameter logic INIT = 1'b0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // ========================================================
    // shift chain; a change counts once the second and third agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            level <= INIT;
        end
        else
        begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
                level <= s3_reg;
        end
    end
endmodule

// [tb/ltmc_dev_model.sv]
// behavioural transceiver seen from its pins: modes, ignore window, faults
// assumes the bench clock as time base; pins resolved by the bench
`timescale 1ns/1ps
module ltmc_dev_model
#(
    parameter int IGN_CYC = 20,
    parameter logic STRAP = 1'b0
)
(
    input wire logic clk,
    input wire logic vbat,
    input wire logic cs_wake,
    input wire logic txd,
    input wire logic txd_act,
    input wire logic bus_short,
    input wire logic hot,
    output logic rxd,
    output logic fault_slope,
    output logic pwr_good,
    output logic reg_on,
    output logic tx_on,
    output logic bad_drive,
    output logic [2:0] st
);
    localparam logic [2:0] S_OFF = 3'h0;
    localparam logic [2:0] S_RDY1 = 3'h1;
    localparam logic [2:0] S_RDY = 3'h2;
    localparam logic [2:0] S_OPER = 3'h4;
    localparam logic [2:0] S_DOWN = 3'h5;
    int ign;
    int por;
    logic cs_q;
    logic hot_q;
    logic slope;
    logic bus;
    logic fault_n;
    // ========================================================
    // mode sequencing; edges seen at the rising clock, the bench drives
    // at the falling one so the two never race
    always @(posedge clk or negedge vbat)
    begin
        if (!vbat)
        begin
            st <= S_OFF;
            por <= 0;
            ign <= IGN_CYC;
            cs_q <= 1'b0;
            hot_q <= 1'b0;
            bad_drive <= 1'b0;
        end
        else
        begin
            cs_q <= cs_wake;
            hot_q <= hot;
            if (ign > 0 && st != S_OFF)
                ign <= ign - 1;
            if (st == S_DOWN && txd_act && txd)
                bad_drive <= 1'b1;
            if (st == S_OFF)
            begin
                por <= por + 1;
                if (por == 3)
                begin
                    slope <= STRAP;
                    st <= cs_wake ? S_RDY1 : S_RDY;
                end
            end
            else if (hot_q && !hot)
                st <= S_RDY1;
            else if (!hot && ign == 0)
                case (st)
                    S_RDY1: if (cs_q && !cs_wake) st <= S_RDY;
                    S_RDY: if (!cs_q && cs_wake) st <= S_OPER;
                    S_OPER: if (cs_q && !cs_wake) st <= S_DOWN;
                    S_DOWN:
                        if (!cs_q && cs_wake)
                            st <= S_OPER;
                        else if (!bus)
                            st <= S_RDY;
                    default: ;
                endcase
        end
    end
    // ========================================================
    // pin levels; the strap resistor shows only while powering on
    assign reg_on = st != S_OFF && st != S_DOWN;
    assign tx_on = st == S_OPER && !hot;
    assign bus = !(tx_on && !txd) && !bus_short;
    assign rxd = bus;
    assign fault_n = !(hot || (tx_on && txd && bus_short));
    assign fault_slope = st == S_OFF ? STRAP : fault_n;
    assign pwr_good = st != S_OFF;
endmodule

// [tb/testbench.sv]
// self-checking bench for the host mode controller against a device model
// assumes the design parameter shortened to a 20-cycle ignore window
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n, vbat, go_oper, go_down, user_txd, bus_short, hot;
    logic user_rxd, link_up, slope_fast, fs_out, fs_oe_n, cs_wake;
    logic txd_pin, txd_oe_n, rxd, dev_fs, pwr_good, reg_on, tx_on;
    logic bad_drive, fs_w, txd_w;
    logic [2:0] mode;
    logic [2:0] dev_st;
    logic [1:0] fault_class;
    int bad_count, compares;
    // ========================================================
    // pin wiring: pull-up on transmit data, strap shared with fault output
    assign txd_w = txd_oe_n ? 1'b1 : txd_pin;
    assign fs_w = fs_oe_n ? dev_fs : fs_out;
    always #25 clk = ~clk;
    ltmc_host #(.IGNORE_CYCLES(20)) i_dut (.clk(clk), .rst_n(rst_n),
        .pwr_good(pwr_good), .go_oper(go_oper), .go_down(go_down),
        .user_txd(user_txd), .user_rxd(user_rxd), .link_up(link_up),
        .slope_fast(slope_fast), .mode(mode), .fault_class(fault_class),
        .rxd_pin(rxd), .fault_slope_pin_in(fs_w),
        .fault_slope_pin_out(fs_out), .fault_slope_pin_oe_n(fs_oe_n),
        .cs_wake_pin(cs_wake), .txd_pin(txd_pin), .txd_pin_oe_n(txd_oe_n));
    ltmc_dev_model #(.IGN_CYC(20), .STRAP(1'b0)) i_dev (.clk(clk),
        .vbat(vbat), .cs_wake(cs_wake), .txd(txd_w), .txd_act(!txd_oe_n),
        .bus_short(bus_short), .hot(hot), .rxd(rxd), .fault_slope(dev_fs),
        .pwr_good(pwr_good), .reg_on(reg_on), .tx_on(tx_on),
        .bad_drive(bad_drive), .st(dev_st));
    // ========================================================
    // compare and wait helpers
    task automatic chk_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_code(input string what, input logic [2:0] exp,
        input logic [2:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait: a missed mode shows up in the compare that follows
    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (mode !== m && n < 200)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    // ========================================================
    // scenarios
    task automatic t_power;
        vbat = 1'b1;
        wait_mode(ltmc_pkg::LTMC_READY);
        chk_code("mode", ltmc_pkg::LTMC_READY, mode);
        chk_bit("slope_fast", 1'b1, slope_fast);
        chk_bit("fs_oe_n", 1'b1, fs_oe_n);
        chk_bit("fs_out", 1'b0, fs_out);
        chk_bit("reg_on", 1'b1, reg_on);
        chk_bit("txd_oe_n", 1'b1, txd_oe_n);
        chk_bit("rxd", 1'b1, rxd);
        $display("done power-up");
    endtask
    task automatic t_refuse;
        go_oper = 1'b1;
        cycles(6);
        chk_code("mode", ltmc_pkg::LTMC_READY, mode);
        chk_bit("cs_wake", 1'b0, cs_wake);
        wait_mode(ltmc_pkg::LTMC_OPER);
        chk_code("mode", ltmc_pkg::LTMC_OPER, mode);
        chk_code("dev_st", 3'h4, dev_st);
        chk_bit("link_up", 1'b1, link_up);
        chk_bit("txd_oe_n", 1'b0, txd_oe_n);
        $display("done ignore window");
    endtask
    task automatic t_tx;
        user_txd = 1'b0;
        cycles(10);
        chk_bit("txd_pin", 1'b0, txd_pin);
        chk_bit("user_rxd", 1'b0, user_rxd);
        user_txd = 1'b1;
        cycles(10);
        chk_bit("user_rxd", 1'b1, user_rxd);
        bus_short = 1'b1;
        cycles(10);
        chk_code("fault", 3'h1, {1'b0, fault_class});
        chk_bit("user_rxd", 1'b0, user_rxd);
        bus_short = 1'b0;
        cycles(10);
        $display("done transmit");
    endtask
    task automatic t_down;
        go_oper = 1'b0;
        go_down = 1'b1;
        wait_mode(ltmc_pkg::LTMC_DOWN);
        go_down = 1'b0;
        chk_code("mode", ltmc_pkg::LTMC_DOWN, mode);
        chk_code("dev_st", 3'h5, dev_st);
        chk_bit("reg_on", 1'b0, reg_on);
        chk_bit("link_up", 1'b0, link_up);
        cycles(5);
        chk_bit("bad_drive", 1'b0, bad_drive);
        $display("done power-down");
    endtask
    task automatic t_cs_wake;
        go_oper = 1'b1;
        wait_mode(ltmc_pkg::LTMC_OPER);
        chk_code("dev_st", 3'h4, dev_st);
        chk_bit("link_up", 1'b1, link_up);
        $display("done wake by select");
    endtask
    task automatic t_bus_wake;
        bus_short = 1'b1;
        cycles(8);
        bus_short = 1'b0;
        wait_mode(ltmc_pkg::LTMC_READY);
        chk_code("mode", ltmc_pkg::LTMC_READY, mode);
        chk_code("dev_st", 3'h2, dev_st);
        chk_bit("reg_on", 1'b1, reg_on);
        go_oper = 1'b1;
        wait_mode(ltmc_pkg::LTMC_OPER);
        chk_code("dev_st", 3'h4, dev_st);
        $display("done wake by bus");
    endtask
    task automatic t_thermal;
        user_txd = 1'b0;
        cycles(4);
        hot = 1'b1;
        go_oper = 1'b0;
        // the class stands only until the host leaves operation
        cycles(5);
        chk_bit("tx_on", 1'b0, tx_on);
        chk_bit("user_rxd", 1'b1, user_rxd);
        chk_code("fault", 3'h2, {1'b0, fault_class});
        cycles(3);
        hot = 1'b0;
        cycles(1);
        chk_code("dev_st", 3'h1, dev_st);
        wait_mode(ltmc_pkg::LTMC_READY);
        chk_code("dev_st", 3'h2, dev_st);
        user_txd = 1'b1;
        go_oper = 1'b1;
        wait_mode(ltmc_pkg::LTMC_OPER);
        chk_code("dev_st", 3'h4, dev_st);
        $display("done thermal");
    endtask
    // ========================================================
    // verdict and hang guard
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // whole run is well under a thousand cycles
    initial
    begin
        #(4000 * 50);
        bad_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        wrap_up();
    end
    initial
    begin
        {rst_n, vbat, go_oper, go_down, user_txd, bus_short, hot} = 7'h00;
        bad_count = 0;
        compares = 0;
        cycles(2);
        rst_n = 1'b1;
        cycles(3);
        t_power();
        t_refuse();
        t_tx();
        t_down();
        t_cs_wake();
        t_down();
        t_bus_wake();
        t_thermal();
        wrap_up();
    end
endmodule
